// >>> include/ulsc_cfg.svh
// constants of the lin status and control block
`ifndef ULSC_CFG_SVH
`define ULSC_CFG_SVH
// register word addresses
`define ULSC_ADDR_W 2
`define ULSC_OFS_STATUS2 2'h0
`define ULSC_OFS_CONTROL3 2'h1
`define ULSC_OFS_IRQ_MASK 2'h2
// lin_status_two fields
`define ULSC_S2_BRK_FLAG 7
`define ULSC_S2_EDGE_FLAG 6
`define ULSC_S2_RX_INV 4
`define ULSC_S2_WAKE_IDLE 3
`define ULSC_S2_LONG_BRK 2
`define ULSC_S2_BRK_EN 1
`define ULSC_S2_ACTIVE 0
// serial_control_three fields
`define ULSC_C3_RX_NINTH 7
`define ULSC_C3_TX_NINTH 6
`define ULSC_C3_DRIVE_OUT 5
`define ULSC_C3_TX_INV 4
`define ULSC_C3_OVR_EN 3
`define ULSC_C3_NOISE_EN 2
`define ULSC_C3_FRAME_EN 1
`define ULSC_C3_PAR_EN 0
// reset values
`define ULSC_RST_BYTE 8'h00
`define ULSC_RST_SYNC 3'h7
// break lengths in bit times
`define ULSC_TX_BRK_SHORT 4'hA
`define ULSC_TX_BRK_LONG 4'hD
`define ULSC_RX_BRK_NORMAL 4'hA
`define ULSC_RX_BRK_RAISED 4'hB
`endif

// >>> include/ulsc_pkg.sv
// types of the lin status and control block
`default_nettype none
package ulsc_pkg;
  // break generator states, gray along idle -> break
  typedef enum logic [1:0] {
    ULSC_TX_IDLE = 2'h0,
    ULSC_TX_BRK = 2'h1
  } ulsc_tx_type;

  // whole state of the block
  typedef struct packed {
    logic [2:0] sync;
    logic rx_level;
    logic brk_flag;
    logic edge_flag;
    logic rx_invert;
    logic wake_idle;
    logic long_break;
    logic brk_enable;
    logic active;
    logic rx_ninth;
    logic tx_ninth;
    logic drive_out;
    logic tx_invert;
    logic [3:0] err_en;
    logic [1:0] mask;
    logic [3:0] low_cnt;
    logic brk_seen;
    ulsc_tx_type tx_state;
    logic [3:0] tx_cnt;
    logic tx_pin;
    logic err_irq;
    logic irq;
    logic [7:0] rdata;
  } ulsc_state_type;
endpackage
`default_nettype wire

// >>> src/ulsc_top.sv
// lin status two and control three logic of the serial interface
`include "ulsc_cfg.svh"
`default_nettype none
module ulsc_top
  import ulsc_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic RSTN_IN,
  // register port
  input wire logic [`ULSC_ADDR_W-1:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [7:0] RDATA_OUT,
  // serial pins
  input wire logic SERIAL_IN_PIN_IN,
  input wire logic SERIAL_OUT_PIN_IN,
  output logic SERIAL_OUT_PIN_OUT,
  output logic SERIAL_OUT_OE_OUT,
  // from the rest of the interface
  input wire logic BIT_TICK_IN,
  input wire logic NINE_BIT_IN,
  input wire logic LOOP_MODE_IN,
  input wire logic RECEIVE_SOURCE_IN,
  input wire logic RX_STANDBY_IN,
  input wire logic START_DETECT_IN,
  input wire logic IDLE_DETECT_IN,
  input wire logic FRAME_ERR_IN,
  input wire logic BUF_FULL_IN,
  input wire logic RX_NINTH_IN,
  input wire logic BREAK_REQ_IN,
  input wire logic TX_SHIFT_IN,
  input wire logic OVERRUN_FLAG_IN,
  input wire logic NOISE_FLAG_IN,
  input wire logic FRAMING_FLAG_IN,
  input wire logic PARITY_FLAG_IN,
  // to the rest of the interface
  output logic RX_DATA_OUT,
  output logic IDLE_SET_OUT,
  output logic FRAME_ERR_SET_OUT,
  output logic BUF_FULL_SET_OUT,
  output logic BREAK_DETECT_OUT,
  output logic BREAK_BUSY_OUT,
  output logic TX_NINTH_OUT,
  output logic ERR_IRQ_OUT,
  output logic IRQ_OUT
);

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------

  // register select, used for writes
  function automatic logic sel(input logic [`ULSC_ADDR_W-1:0] a,
                               input logic [`ULSC_ADDR_W-1:0] ofs);
    sel = (a == ofs);
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------

  ulsc_state_type state_reg; // every flip-flop of the block
  ulsc_state_type state_next; // its next value
  logic rx_eff; // receive level after inversion
  logic rx_eff_prev; // same, from the next rx_level value
  logic edge_hit; // active edge seen this cycle
  logic [3:0] rx_thresh; // low bit times that make a break
  logic [3:0] tx_len; // bit times of a sent break
  logic brk_hit; // break threshold reached now
  logic wr_s2; // write to lin_status_two
  logic wr_c3; // write to serial_control_three
  logic [3:0] err_vec; // raw error flags

  // ----------------------------------------
  // combinational next state
  // ----------------------------------------

  // one pass computes every next value
  always_comb
  begin
    state_next = state_reg;
    wr_s2 = WR_IN && sel(ADDR_IN, `ULSC_OFS_STATUS2);
    wr_c3 = WR_IN && sel(ADDR_IN, `ULSC_OFS_CONTROL3);
    err_vec = {OVERRUN_FLAG_IN, NOISE_FLAG_IN, FRAMING_FLAG_IN,
               PARITY_FLAG_IN};

    // pin synchroniser; first stage feeds only the second
    state_next.sync = {state_reg.sync[1:0], SERIAL_IN_PIN_IN};
    // a change counts once stages two and three agree
    if (state_reg.sync[1] == state_reg.sync[2])
    begin
      state_next.rx_level = state_reg.sync[2];
    end

    // inversion ahead of all receive logic
    rx_eff = state_reg.rx_level ^ state_reg.rx_invert;
    rx_eff_prev = state_next.rx_level ^ state_reg.rx_invert;
    // active edge is a falling edge of the inverted line
    edge_hit = rx_eff && !rx_eff_prev;

    // thresholds, nine-bit mode adds one bit time
    rx_thresh = (state_reg.brk_enable ? `ULSC_RX_BRK_RAISED
                                      : `ULSC_RX_BRK_NORMAL)
                + {3'h0, NINE_BIT_IN};
    tx_len = (state_reg.long_break ? `ULSC_TX_BRK_LONG
                                   : `ULSC_TX_BRK_SHORT)
             + {3'h0, NINE_BIT_IN};

    // low-time counter, restarted by any high level
    brk_hit = 1'b0;
    if (rx_eff)
    begin
      state_next.low_cnt = 4'h0;
      state_next.brk_seen = 1'b0;
    end
    else if (BIT_TICK_IN && !state_reg.brk_seen)
    begin
      // saturates at the threshold; reported once per low stretch
      if (state_reg.low_cnt + 4'h1 == rx_thresh)
      begin
        brk_hit = 1'b1;
        state_next.brk_seen = 1'b1;
      end
      state_next.low_cnt = state_reg.low_cnt + 4'h1;
    end

    // break flag: set only with detection enabled; set beats clear
    state_next.brk_flag = (state_reg.brk_flag &&
      !(wr_s2 && WDATA_IN[`ULSC_S2_BRK_FLAG])) ||
      (brk_hit && state_reg.brk_enable);
    // edge flag, same clearing scheme
    state_next.edge_flag = (state_reg.edge_flag &&
      !(wr_s2 && WDATA_IN[`ULSC_S2_EDGE_FLAG])) || edge_hit;

    // receiver active: start sets, idle line clears
    if (START_DETECT_IN)
    begin
      state_next.active = 1'b1;
    end
    else if (IDLE_DETECT_IN)
    begin
      state_next.active = 1'b0;
    end

    // ninth bit follows the character into the buffer
    if (BUF_FULL_IN && !state_reg.brk_enable)
    begin
      state_next.rx_ninth = RX_NINTH_IN;
    end

    // writable control bits
    if (wr_s2)
    begin
      state_next.rx_invert = WDATA_IN[`ULSC_S2_RX_INV];
      state_next.wake_idle = WDATA_IN[`ULSC_S2_WAKE_IDLE];
      state_next.long_break = WDATA_IN[`ULSC_S2_LONG_BRK];
      state_next.brk_enable = WDATA_IN[`ULSC_S2_BRK_EN];
    end
    if (wr_c3)
    begin
      // ninth tx bit holds until software rewrites it
      state_next.tx_ninth = WDATA_IN[`ULSC_C3_TX_NINTH];
      state_next.drive_out = WDATA_IN[`ULSC_C3_DRIVE_OUT];
      state_next.tx_invert = WDATA_IN[`ULSC_C3_TX_INV];
      state_next.err_en = WDATA_IN[`ULSC_C3_OVR_EN:`ULSC_C3_PAR_EN];
    end
    if (WR_IN && sel(ADDR_IN, `ULSC_OFS_IRQ_MASK))
    begin
      state_next.mask = WDATA_IN[7:6];
    end

    // break generator
    case (state_reg.tx_state)
      ULSC_TX_IDLE:
      begin
        // a request waits for nothing; the shifter hands it over
        if (BREAK_REQ_IN)
        begin
          state_next.tx_state = ULSC_TX_BRK;
          state_next.tx_cnt = 4'h0;
        end
      end
      ULSC_TX_BRK:
      begin
        if (BIT_TICK_IN)
        begin
          state_next.tx_cnt = state_reg.tx_cnt + 4'h1;
          // last bit time of the break ends here
          if (state_reg.tx_cnt + 4'h1 == tx_len)
          begin
            state_next.tx_state = ULSC_TX_IDLE;
          end
        end
      end
      default:
      begin
        state_next.tx_state = ULSC_TX_IDLE;
      end
    endcase

    // pin level: break forces space, then polarity applies
    state_next.tx_pin = ((state_next.tx_state == ULSC_TX_BRK)
                         ? 1'b0 : TX_SHIFT_IN)
                        ^ state_next.tx_invert;

    // error request from enabled flags
    state_next.err_irq = |(err_vec & state_reg.err_en);

    // level interrupt from unmasked sticky flags
    state_next.irq = |({state_next.brk_flag, state_next.edge_flag}
                       & state_next.mask);

    // read data stands one cycle, zero otherwise
    state_next.rdata = `ULSC_RST_BYTE;
    if (RD_IN)
    begin
      case (ADDR_IN)
        `ULSC_OFS_STATUS2:
        begin
          state_next.rdata = {state_reg.brk_flag, state_reg.edge_flag,
            1'b0, state_reg.rx_invert, state_reg.wake_idle,
            state_reg.long_break, state_reg.brk_enable,
            state_reg.active};
        end
        `ULSC_OFS_CONTROL3:
        begin
          state_next.rdata = {state_reg.rx_ninth, state_reg.tx_ninth,
            state_reg.drive_out, state_reg.tx_invert, state_reg.err_en};
        end
        `ULSC_OFS_IRQ_MASK:
        begin
          state_next.rdata = {state_reg.mask, 6'h00};
        end
        default:
        begin
          // unmapped address reads as zero
          state_next.rdata = `ULSC_RST_BYTE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------

  // synchronous reset to constants only
  always_ff @(posedge CLOCK_IN)
  begin
    if (!RSTN_IN)
    begin
      state_reg <= '0;
      state_reg.sync <= `ULSC_RST_SYNC;
      state_reg.rx_level <= 1'b1;
      state_reg.tx_pin <= 1'b1;
      state_reg.tx_state <= ULSC_TX_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------

  assign RDATA_OUT = state_reg.rdata;
  assign RX_DATA_OUT = rx_eff;
  // idle on wake reported only when asked for
  assign IDLE_SET_OUT = IDLE_DETECT_IN &&
                        (!RX_STANDBY_IN || state_reg.wake_idle);
  // framing and full flags held off while detecting breaks
  assign FRAME_ERR_SET_OUT = FRAME_ERR_IN && BUF_FULL_IN &&
                             !state_reg.brk_enable;
  assign BUF_FULL_SET_OUT = BUF_FULL_IN && !state_reg.brk_enable;
  assign BREAK_DETECT_OUT = brk_hit;
  assign BREAK_BUSY_OUT = (state_reg.tx_state == ULSC_TX_BRK);
  assign TX_NINTH_OUT = state_reg.tx_ninth;
  assign SERIAL_OUT_PIN_OUT = state_reg.tx_pin;
  // single wire: pin turns to input unless drive_out is set
  assign SERIAL_OUT_OE_OUT = !(LOOP_MODE_IN && RECEIVE_SOURCE_IN) ||
                             state_reg.drive_out;
  assign ERR_IRQ_OUT = state_reg.err_irq;
  assign IRQ_OUT = state_reg.irq;

  // ----------------------------------------
  // assertions
  // ----------------------------------------

  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RSTN_IN);

  property p_brk_flag_set;
    brk_hit && state_reg.brk_enable |=> state_reg.brk_flag;
  endproperty
  a_brk_flag_set: assert property (p_brk_flag_set)
    else $error("break flag not set");

  property p_brk_flag_off;
    !state_reg.brk_enable && !state_reg.brk_flag
      && !WR_IN |=> !state_reg.brk_flag;
  endproperty
  a_brk_flag_off: assert property (p_brk_flag_off)
    else $error("break flag set while detection off");

  property p_edge_flag;
    edge_hit |=> state_reg.edge_flag;
  endproperty
  a_edge_flag: assert property (p_edge_flag)
    else $error("edge flag missed");

  property p_rx_invert;
    RX_DATA_OUT == (state_reg.rx_level ^ state_reg.rx_invert);
  endproperty
  a_rx_invert: assert property (p_rx_invert)
    else $error("receive inversion wrong");

  property p_idle_wake;
    IDLE_DETECT_IN && RX_STANDBY_IN && !state_reg.wake_idle
      |-> !IDLE_SET_OUT;
  endproperty
  a_idle_wake: assert property (p_idle_wake)
    else $error("idle set on wake");

  property p_brk_len;
    $rose(BREAK_BUSY_OUT) && !NINE_BIT_IN && !state_reg.long_break
      && $stable(NINE_BIT_IN) |-> state_reg.tx_cnt == 4'h0;
  endproperty
  a_brk_len: assert property (p_brk_len)
    else $error("break count not restarted");

  property p_brk_end;
    BREAK_BUSY_OUT && BIT_TICK_IN && state_reg.tx_cnt + 4'h1 == tx_len
      |=> !BREAK_BUSY_OUT;
  endproperty
  a_brk_end: assert property (p_brk_end)
    else $error("break too long");

  property p_thresh;
    brk_hit |-> state_reg.low_cnt + 4'h1 == rx_thresh && !rx_eff;
  endproperty
  a_thresh: assert property (p_thresh)
    else $error("break threshold wrong");

  property p_block;
    state_reg.brk_enable |-> !FRAME_ERR_SET_OUT && !BUF_FULL_SET_OUT;
  endproperty
  a_block: assert property (p_block)
    else $error("flags not blocked");

  property p_active;
    START_DETECT_IN |=> state_reg.active;
  endproperty
  a_active: assert property (p_active)
    else $error("active flag missed");

  property p_oe;
    LOOP_MODE_IN && RECEIVE_SOURCE_IN && !state_reg.drive_out
      |-> !SERIAL_OUT_OE_OUT;
  endproperty
  a_oe: assert property (p_oe)
    else $error("pin driven in input mode");

  property p_tx_break_level;
    BREAK_BUSY_OUT ##1 BREAK_BUSY_OUT
      |-> SERIAL_OUT_PIN_OUT == state_reg.tx_invert;
  endproperty
  a_tx_break_level: assert property (p_tx_break_level)
    else $error("break level wrong");

  property p_err_irq;
    (|(err_vec & state_reg.err_en)) |=> ERR_IRQ_OUT;
  endproperty
  a_err_irq: assert property (p_err_irq)
    else $error("error request missing");

endmodule
`default_nettype wire

// >>> testbench/ulsc_node_model.sv
// remote serial node model driving the receive line
`default_nettype none
module ulsc_node_model
(
  input wire logic clk_in,
  input wire logic tick_in,
  input wire logic go_in,
  input wire logic [3:0] len_in,
  output logic busy_out,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic armed_reg = 1'b0; // waiting for a bit boundary
  logic [3:0] cnt_reg = 4'h0; // bit times still low
  initial line_out = 1'b1; // idle mark level
  // a low stretch starts on a tick so the far end sees whole bits
  always @(posedge clk_in)
  begin
    if (go_in)
      armed_reg <= 1'b1;
    else if (armed_reg && tick_in)
    begin
      armed_reg <= 1'b0;
      cnt_reg <= len_in;
      line_out <= 1'b0;
    end
    else if (!line_out && tick_in)
    begin
      // release right after the last bit time
      cnt_reg <= cnt_reg - 4'h1;
      if (cnt_reg == 4'h1)
        line_out <= 1'b1;
    end
  end
  assign busy_out = armed_reg || !line_out;
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench of the lin status and control block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------
  // stimulus and observed nets
  // ----------------------------
  logic clk = 0, rstn = 0, wr = 0, rd = 0, tick = 0, go = 0;
  logic nine = 0, loopm = 0, receive_source_select = 0, stby = 0, shift = 1;
  logic [1:0] addr = 0;
  logic [7:0] wd = 0;
  logic [3:0] errf = 0, len = 0, ev = 0; // ev: start idle frame brk
  logic [2:0] tc = 0; // tick divider
  logic [7:0] rdat;
  logic pin, oe, rxd, idl, fes, bfs, det, bbusy, t9, eirq, irq;
  logic pbusy, line;
  logic [7:0] blen [4] = '{8'h0A, 8'h0D, 8'h0B, 8'h0E};
  int n_mismatch = 0, cmp_count = 0, i, base;
  int n_det = 0, n_idl = 0, n_fe = 0, n_bf = 0, n_btk = 0;

  always #2 clk = ~clk;
  // one bit time is eight clocks, long enough to outrun the sync
  always @(posedge clk)
  begin
    tc <= tc + 3'h1;
    tick <= (tc == 3'h7);
    n_det <= n_det + (det === 1'b1);
    n_idl <= n_idl + (idl === 1'b1);
    n_fe <= n_fe + (fes === 1'b1);
    n_bf <= n_bf + (bfs === 1'b1);
    n_btk <= n_btk + (bbusy === 1'b1 && tick);
  end

  ulsc_top dut_u (
    .CLOCK_IN(clk), .RSTN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wd),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdat),
    .SERIAL_IN_PIN_IN(line), .SERIAL_OUT_PIN_IN(oe ? pin : 1'b1),
    .SERIAL_OUT_PIN_OUT(pin), .SERIAL_OUT_OE_OUT(oe),
    .BIT_TICK_IN(tick), .NINE_BIT_IN(nine), .LOOP_MODE_IN(loopm),
    .RECEIVE_SOURCE_IN(receive_source_select), .RX_STANDBY_IN(stby),
    .START_DETECT_IN(ev[0]), .IDLE_DETECT_IN(ev[1]),
    .FRAME_ERR_IN(ev[2]), .BUF_FULL_IN(ev[2]), .RX_NINTH_IN(ev[2]),
    .BREAK_REQ_IN(ev[3]), .TX_SHIFT_IN(shift),
    .OVERRUN_FLAG_IN(errf[3]), .NOISE_FLAG_IN(errf[2]),
    .FRAMING_FLAG_IN(errf[1]), .PARITY_FLAG_IN(errf[0]),
    .RX_DATA_OUT(rxd), .IDLE_SET_OUT(idl), .FRAME_ERR_SET_OUT(fes),
    .BUF_FULL_SET_OUT(bfs), .BREAK_DETECT_OUT(det),
    .BREAK_BUSY_OUT(bbusy), .TX_NINTH_OUT(t9), .ERR_IRQ_OUT(eirq),
    .IRQ_OUT(irq));

  ulsc_node_model node_u (.clk_in(clk), .tick_in(tick), .go_in(go),
    .len_in(len), .busy_out(pbusy), .line_out(line));

  // ----------------------------
  // bus, event and check tasks
  // ----------------------------
  task automatic summarize();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask

  task automatic wrt(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdat, e);
  endtask

  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 4'h0;
    // let the edge counters take this edge before anyone compares them
    #1;
  endtask

  // bounded wait for a level; a hang ends the run
  task automatic hold(ref logic s, input logic v);
    int k;
    k = 0;
    #1;
    while (s !== v && k < 500)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= 500)
    begin
      n_mismatch++;
      summarize();
    end
  endtask

  // low stretch of n bit times from the far node
  task automatic send(input logic [3:0] n);
    @(posedge clk);
    len <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    hold(pbusy, 1'b0);
    repeat (12) @(posedge clk);
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    wrt(2'h3, 8'hFF);
    wrt(2'h0, 8'h21);
    rdc(2'h0, 8'h00);
    rdc(2'h1, 8'h00);
    rdc(2'h3, 8'h00);
    chk(pin, 8'h01);
    chk(oe, 8'h01);
    // threshold table over detect enable and nine-bit mode
    for (i = 0; i < 4; i++)
    begin
      wrt(2'h0, {6'h00, i[0], 1'b0});
      nine <= i[1];
      base = n_det;
      send(4'h9 + i[0] + i[1]);
      send(4'hA + i[0] + i[1]);
      chk(8'(n_det - base), 8'h01);
      if (i == 0)
        rdc(2'h0, 8'h40);
    end
    rdc(2'h0, 8'hC2);
    chk(irq, 8'h00);
    wrt(2'h2, 8'h80);
    hold(irq, 1'b1);
    wrt(2'h0, 8'h82);
    hold(irq, 1'b0);
    rdc(2'h0, 8'h42);
    // inverted idle looks like one endless break
    wrt(2'h0, 8'h50);
    base = n_det;
    repeat (120) @(posedge clk);
    chk(rxd, 8'h00);
    chk(8'(n_det - base), 8'h01);
    wrt(2'h0, 8'h50);
    send(4'h3);
    rdc(2'h0, 8'h50);
    // receive flags blocked while detection is on
    wrt(2'h0, 8'h42);
    pulse(4'h4);
    chk(8'(n_fe + n_bf), 8'h00);
    rdc(2'h1, 8'h00);
    wrt(2'h0, 8'h40);
    pulse(4'h4);
    chk(8'(n_fe), 8'h01);
    chk(8'(n_bf), 8'h01);
    rdc(2'h1, 8'h80);
    // receiver active and wake idle
    pulse(4'h1);
    rdc(2'h0, 8'h01);
    stby <= 1'b1;
    pulse(4'h2);
    rdc(2'h0, 8'h00);
    chk(8'(n_idl), 8'h00);
    wrt(2'h0, 8'h08);
    pulse(4'h2);
    rdc(2'h0, 8'h08);
    chk(8'(n_idl), 8'h01);
    stby <= 1'b0;
    // break lengths, inverted output on nine-bit rows
    for (i = 0; i < 4; i++)
    begin
      wrt(2'h0, {5'h00, i[0], 2'h0});
      wrt(2'h1, {3'h0, i[1], 4'h0});
      nine <= i[1];
      base = n_btk;
      pulse(4'h8);
      hold(bbusy, 1'b1);
      chk(pin, 8'(i[1]));
      hold(bbusy, 1'b0);
      chk(8'(n_btk - base), blen[i]);
      chk(pin, 8'(!i[1]));
    end
    wrt(2'h1, 8'h40);
    chk(t9, 8'h01);
    rdc(2'h1, 8'hC0);
    @(posedge clk);
    loopm <= 1'b1;
    receive_source_select <= 1'b1;
    @(posedge clk);
    #1 chk(oe, 8'h00);
    wrt(2'h1, 8'h60);
    chk(oe, 8'h01);
    // each error enable against its own flag and the others
    for (i = 0; i < 4; i++)
    begin
      wrt(2'h1, 8'(1 << i));
      errf <= ~4'(1 << i);
      repeat (3) @(posedge clk);
      #1 chk(eirq, 8'h00);
      errf <= 4'(1 << i);
      repeat (3) @(posedge clk);
      #1 chk(eirq, 8'h01);
      errf <= 4'h0;
    end
    summarize();
  end
endmodule
`default_nettype wire
